// file: hw/flic_top.sv
// Four-level interrupt controller with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps
module flic_top
   import flic_pkg::*;
(
   input  wire logic               ref_clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               hsel_in,
   input  wire logic [31:0]        haddr_in,
   input  wire logic [1:0]         htrans_in,
   input  wire logic               hwrite_in,
   input  wire logic [2:0]         hsize_in,
   input  wire logic [31:0]        hwdata_in,
   input  wire logic               hready_in,
   output logic [31:0]             hrdata_out,
   output logic                    hreadyout_out,
   output logic                    hresp_out,
   input  wire logic               external_request_zero_in,
   input  wire logic               external_request_one_in,
   input  wire logic               timer0_ovf_in,
   input  wire logic               timer1_ovf_in,
   input  wire logic               timer2_ovf_in,
   input  wire logic               serial_req_in,
   input  wire logic               keypad_req_in,
   input  wire logic               counter_array_req_in,
   input  wire logic               irq_ack_in,
   input  wire logic               irq_return_in,
   output logic                    irq_req_out,
   output logic [15:0]             irq_vector_out,
   output logic [1:0]              irq_level_out,
   output logic                    evt_irq_out
);
   logic [7:0]         interrupt_enable;
   logic [7:0]         second_enable_register;
   logic [7:0]         prio_low;
   logic [7:0]         prio_high;
   logic [7:0]         prio_low2;
   logic [7:0]         prio_high2;
   logic [NUM_EVT-1:0] evt_status;
   logic [NUM_EVT-1:0] evt_mask;
   logic [3:0]         active_lvls;
   flic_state_t        state;
   logic [2:0]         offer_idx;
   logic [1:0]         offer_lvl;

   logic               ph_valid;
   logic               ph_write;
   logic [7:0]         ph_addr;
   logic [NUM_SRC-1:0] src_req;
   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0] eligible;
   logic [NUM_SRC-1:0] prio_h_vec;
   logic [NUM_SRC-1:0] prio_l_vec;
   logic [NUM_SRC-1:0] lvl_req [4];
   logic [3:0]         lvl_hit;
   logic [2:0]         lvl_idx [4];
   logic               win_hit;
   logic [2:0]         win_idx;
   logic [1:0]         win_lvl;
   logic               preempt_ok;
   logic [1:0]         top_active;
   logic               any_active;
   logic               do_grant;
   logic               do_return;
   logic               offer_go;
   logic [3:0]         next_active;
   logic [NUM_EVT-1:0] evt_set;
   logic               rd_status;
   logic [31:0]        next_rdata;
   logic               wr_en;

   assign src_req = {keypad_req_in, counter_array_req_in, timer2_ovf_in, serial_req_in,
                     timer1_ovf_in, external_request_one_in, timer0_ovf_in,
                     external_request_zero_in};
   assign src_en[SRC_KBD]  = second_enable_register[BIT_KBD_EN];
   assign src_en[SRC_EXT0] = interrupt_enable[BIT_EXT0_EN];
   assign src_en[SRC_TMR0] = interrupt_enable[BIT_TMR0_EN];
   assign src_en[SRC_EXT1] = interrupt_enable[BIT_EXT1_EN];
   assign src_en[SRC_TMR1] = interrupt_enable[BIT_TMR1_EN];
   assign src_en[SRC_SER]  = interrupt_enable[BIT_SER_EN];
   // Timer 2 enable gates its request
   assign src_en[SRC_TMR2] = interrupt_enable[BIT_TMR2_EN];
   assign src_en[SRC_CA]   = interrupt_enable[BIT_CA_EN];
   assign eligible = src_req & src_en & {NUM_SRC{interrupt_enable[BIT_GLOBAL_EN]}};

   // Priority bit vectors reordered to polling index
   assign prio_h_vec = {prio_high2[0], prio_high[6], prio_high[5], prio_high[4],
                        prio_high[3], prio_high[2], prio_high[1], prio_high[0]};
   assign prio_l_vec = {prio_low2[0], prio_low[6], prio_low[5], prio_low[4],
                        prio_low[3], prio_low[2], prio_low[1], prio_low[0]};

   // High and low bit select level
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         lvl_req[l] = eligible & (l[1] ? prio_h_vec : ~prio_h_vec)
                               & (l[0] ? prio_l_vec : ~prio_l_vec);
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lvl
         flic_lvl_arb u_arb (
            .req_in  (lvl_req[g]),
            .hit_out (lvl_hit[g]),
            .idx_out (lvl_idx[g])
         );
      end
   endgenerate

   always_comb begin
      win_hit = 1'b0;
      win_idx = 3'h0;
      win_lvl = 2'h0;
      for (int l = 0; l < 4; l++) begin
         if (lvl_hit[l]) begin
            win_hit = 1'b1;
            win_idx = lvl_idx[l];
            win_lvl = 2'(l);
         end
      end
   end

   always_comb begin
      any_active = |active_lvls;
      top_active = 2'h0;
      for (int l = 0; l < 4; l++) begin
         if (active_lvls[l]) begin
            top_active = 2'(l);
         end
      end
   end

   // Strictly higher level preempts; level 3 is never exceeded
   assign preempt_ok = win_hit && (!any_active || (win_lvl > top_active));

   assign do_grant  = (state == FLIC_OFFER) && irq_ack_in;
   assign do_return = irq_return_in && any_active;
   assign offer_go  = (state == FLIC_IDLE) && preempt_ok && !do_return;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state     <= FLIC_IDLE;
         offer_idx <= 3'h0;
         offer_lvl <= 2'h0;
      end else begin
         case (state)
            FLIC_IDLE: begin
               if (offer_go) begin
                  state     <= FLIC_OFFER;
                  offer_idx <= win_idx;
                  offer_lvl <= win_lvl;
               end
            end
            FLIC_OFFER: begin
               if (irq_ack_in) begin
                  state <= FLIC_IDLE;
               end
            end
            default: state <= FLIC_IDLE;
         endcase
      end
   end

   // Return frees the top level before a grant marks its own
   always_comb begin
      next_active = active_lvls;
      if (do_return) begin
         next_active[top_active] = 1'b0;
      end
      if (do_grant) begin
         next_active[offer_lvl] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         active_lvls <= 4'h0;
      end else begin
         active_lvls <= next_active;
      end
   end

   function automatic logic [15:0] vec_of(input logic [2:0] idx);
      case (idx)
         3'h0:    vec_of = VEC_EXT0;
         3'h1:    vec_of = VEC_TMR0;
         3'h2:    vec_of = VEC_EXT1;
         3'h3:    vec_of = VEC_TMR1;
         3'h4:    vec_of = VEC_SER;
         3'h5:    vec_of = VEC_TMR2;
         3'h6:    vec_of = VEC_CA;
         3'h7:    vec_of = VEC_KBD;
         default: vec_of = VEC_EXT0;
      endcase
   endfunction

   // Vector and level latched with the offer
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_vector_out <= 16'h0000;
         irq_level_out  <= 2'h0;
      end else if (offer_go) begin
         irq_vector_out <= vec_of(win_idx);
         irq_level_out  <= win_lvl;
      end
   end

   // Strobe raised with the offer, dropped on acknowledge
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_req_out <= 1'b0;
      end else if (offer_go) begin
         irq_req_out <= 1'b1;
      end else if (do_grant) begin
         irq_req_out <= 1'b0;
      end
   end

   // AHB-Lite address phase capture; the word index sits in haddr[9:2]
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (hready_in) begin
         ph_valid <= hsel_in && htrans_in[1];
         ph_write <= hwrite_in;
         ph_addr  <= haddr_in[9:2];
      end
   end

   assign wr_en     = ph_valid && ph_write;
   assign rd_status = hsel_in && htrans_in[1] && !hwrite_in && hready_in
                      && (haddr_in[9:2] == OFS_EVT_STATUS);

   // Enable registers reset to zero, bit-writable by word write
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         interrupt_enable       <= RST_IRQ_ENABLE;
         second_enable_register <= RST_IRQ_ENABLE;
      end else if (wr_en) begin
         case (ph_addr)
            OFS_IRQ_ENABLE:  interrupt_enable       <= hwdata_in[7:0];
            // Only the keypad bit exists; the rest read zero
            OFS_IRQ_ENABLE2: second_enable_register <= hwdata_in[7:0] & 8'h01;
            default: ;
         endcase
      end
   end

   // Priority pairs; reserved bits are held at zero
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prio_low   <= RST_PRIO;
         prio_high  <= RST_PRIO;
         prio_low2  <= RST_PRIO;
         prio_high2 <= RST_PRIO;
      end else if (wr_en) begin
         case (ph_addr)
            OFS_PRIO_LOW:   prio_low   <= hwdata_in[7:0] & PRIO_RSVD_MASK;
            OFS_PRIO_HIGH:  prio_high  <= hwdata_in[7:0] & PRIO_RSVD_MASK;
            OFS_PRIO_LOW2:  prio_low2  <= hwdata_in[7:0] & 8'h01;
            OFS_PRIO_HIGH2: prio_high2 <= hwdata_in[7:0] & 8'h01;
            default: ;
         endcase
      end
   end

   // Event mask, same layout as the status
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         evt_mask <= '0;
      end else if (wr_en && (ph_addr == OFS_EVT_MASK)) begin
         evt_mask <= hwdata_in[NUM_EVT-1:0];
      end
   end

   assign evt_set = {do_return, do_grant && any_active, do_grant};

   // Sticky events; a new event beats the read-clear
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         evt_status <= '0;
      end else begin
         evt_status <= (rd_status ? '0 : evt_status) | evt_set;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         evt_irq_out <= 1'b0;
      end else begin
         evt_irq_out <= |(((rd_status ? '0 : evt_status) | evt_set) & evt_mask);
      end
   end

   // Read data registered in the address phase so it stands during the data phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr_in[9:2])
         OFS_IRQ_ENABLE:  next_rdata[7:0] = interrupt_enable;
         OFS_IRQ_ENABLE2: next_rdata[7:0] = second_enable_register;
         OFS_PRIO_LOW:    next_rdata[7:0] = prio_low;
         OFS_PRIO_HIGH:   next_rdata[7:0] = prio_high;
         OFS_PRIO_LOW2:   next_rdata[7:0] = prio_low2;
         OFS_PRIO_HIGH2:  next_rdata[7:0] = prio_high2;
         OFS_EVT_STATUS:  next_rdata[NUM_EVT-1:0] = evt_status;
         OFS_EVT_MASK:    next_rdata[NUM_EVT-1:0] = evt_mask;
         OFS_ACTIVE:      next_rdata[3:0] = active_lvls;
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
         hrdata_out <= next_rdata;
      end
   end

   // Zero wait states: every transfer ends in its first data cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hreadyout_out <= 1'b1;
      end else begin
         hreadyout_out <= 1'b1;
      end
   end

   // Always OKAY; unmapped words read zero rather than erroring
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hresp_out <= 1'b0;
      end else begin
         hresp_out <= 1'b0;
      end
   end
endmodule

// file: hw/flic_pkg.sv
// Package: register map, field positions, vectors and states for the interrupt controller
// Operation
// - Eight request sources accepted
// - Per-source enable gates forwarding
// - Global enable gates every source
// - Enable register bit layout, global at 7
// - Enable register resets to zero
// - Timer 2 enable allows or blocks
// - Two priority bits give four levels
// - Only strictly higher level preempts
// - Highest level never preempted
// - Higher level wins simultaneous requests
// - Fixed polling order within level
// - Counter array vector 0033H
// - Keypad vector 004BH
// - Conventional vectors for other sources
// - Keypad gated by second enable register
package flic_pkg;
   localparam int          NUM_SRC          = 8;
   // Source index equals polling position
   localparam int          SRC_EXT0         = 0;
   localparam int          SRC_TMR0         = 1;
   localparam int          SRC_EXT1         = 2;
   localparam int          SRC_TMR1         = 3;
   localparam int          SRC_SER          = 4;
   localparam int          SRC_TMR2         = 5;
   localparam int          SRC_CA           = 6;
   localparam int          SRC_KBD          = 7;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0]  OFS_IRQ_ENABLE   = 8'hA8;
   localparam logic [7:0]  OFS_IRQ_ENABLE2  = 8'hB1;
   localparam logic [7:0]  OFS_PRIO_LOW     = 8'hB8;
   localparam logic [7:0]  OFS_PRIO_HIGH    = 8'hB7;
   localparam logic [7:0]  OFS_PRIO_LOW2    = 8'hB2;
   localparam logic [7:0]  OFS_PRIO_HIGH2   = 8'hB3;
   localparam logic [7:0]  OFS_EVT_STATUS   = 8'hC0;
   localparam logic [7:0]  OFS_EVT_MASK     = 8'hC4;
   localparam logic [7:0]  OFS_ACTIVE       = 8'hC8;
   // Enable register fields
   localparam int          BIT_GLOBAL_EN    = 7;
   localparam int          BIT_CA_EN        = 6;
   localparam int          BIT_TMR2_EN      = 5;
   localparam int          BIT_SER_EN       = 4;
   localparam int          BIT_TMR1_EN      = 3;
   localparam int          BIT_EXT1_EN      = 2;
   localparam int          BIT_TMR0_EN      = 1;
   localparam int          BIT_EXT0_EN      = 0;
   localparam int          BIT_KBD_EN       = 0;
   localparam logic [7:0]  RST_IRQ_ENABLE   = 8'h00;
   localparam logic [7:0]  RST_PRIO         = 8'h00;
   localparam logic [7:0]  PRIO_RSVD_MASK   = 8'h7F;
   // Vector addresses by source index
   localparam logic [15:0] VEC_EXT0         = 16'h0003;
   localparam logic [15:0] VEC_TMR0         = 16'h000B;
   localparam logic [15:0] VEC_EXT1         = 16'h0013;
   localparam logic [15:0] VEC_TMR1         = 16'h001B;
   localparam logic [15:0] VEC_SER          = 16'h0023;
   localparam logic [15:0] VEC_TMR2         = 16'h002B;
   localparam logic [15:0] VEC_CA           = 16'h0033;
   localparam logic [15:0] VEC_KBD          = 16'h004B;
   // Event status bits
   localparam int          EVT_GRANT        = 0;
   localparam int          EVT_PREEMPT      = 1;
   localparam int          EVT_RETURN       = 2;
   localparam int          NUM_EVT          = 3;

   typedef enum logic [1:0] {
      FLIC_IDLE  = 2'b00,
      FLIC_OFFER = 2'b01
   } flic_state_t;
endpackage

// file: hw/flic_lvl_arb.sv
// Per-level fixed-order picker: lowest index wins
`timescale 1ns/100ps
module flic_lvl_arb
   import flic_pkg::*;
(
   input  wire logic [NUM_SRC-1:0] req_in,
   output logic                    hit_out,
   output logic [2:0]              idx_out
);
   always_comb begin
      hit_out = 1'b0;
      idx_out = 3'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req_in[i]) begin
            hit_out = 1'b1;
            idx_out = 3'(i);
         end
      end
   end
endmodule

// file: tb/flic_core_model.sv
// Core-side partner: acknowledges offers after a set delay, reports returns
`timescale 1ns/100ps
module flic_core_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       req_in,
   input  wire logic       ret_go_in,
   input  wire logic [3:0] dly_in,
   output logic            ack_out,
   output logic            ret_out
);
   logic [3:0] cnt;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt     <= 4'h0;
         ack_out <= 1'b0;
         ret_out <= 1'b0;
      end else begin
         ret_out <= ret_go_in;
         // Ack is one cycle; the offer is still up when it is sampled
         if (req_in && !ack_out && cnt >= dly_in) begin
            ack_out <= 1'b1;
            cnt     <= 4'h0;
         end else begin
            ack_out <= 1'b0;
            cnt     <= (req_in && !ack_out) ? cnt + 4'h1 : 4'h0;
         end
      end
   end
endmodule

// file: tb/flic_top_chk.sv
// Checker: offer handshake, vectors and nesting of levels
`timescale 1ns/100ps
module flic_top_chk (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        external_request_zero_in,
   input wire logic        external_request_one_in,
   input wire logic        timer0_ovf_in,
   input wire logic        timer1_ovf_in,
   input wire logic        timer2_ovf_in,
   input wire logic        serial_req_in,
   input wire logic        keypad_req_in,
   input wire logic        counter_array_req_in,
   input wire logic        irq_ack_in,
   input wire logic        irq_return_in,
   input wire logic        irq_req_out,
   input wire logic [15:0] irq_vector_out,
   input wire logic [1:0]  irq_level_out
);
   logic [3:0] act;
   logic [1:0] top;

   default clocking dc @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   always_comb begin
      top = act[3] ? 2'h3 : act[2] ? 2'h2 : act[1] ? 2'h1 : 2'h0;
   end

   // Mirror of levels in service; a return frees only the highest one
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         act <= 4'h0;
      end else begin
         // Return and grant in one cycle: the grant's level survives
         if (irq_return_in && |act) begin
            act[top] <= 1'b0;
         end
         if (irq_ack_in && irq_req_out) begin
            act[irq_level_out] <= 1'b1;
         end
      end
   end

   a_req_hold: assert property (irq_req_out && !irq_ack_in |=>
      irq_req_out && $stable(irq_vector_out) && $stable(irq_level_out))
      else $error("offer changed before acknowledge");
   a_req_drop: assert property (irq_req_out && irq_ack_in |=> !irq_req_out)
      else $error("offer kept after acknowledge");
   a_vec_legal: assert property (irq_req_out |-> irq_vector_out inside
      {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h004B})
      else $error("vector outside table");
   a_has_source: assert property ($rose(irq_req_out) |-> $past(|{
      external_request_zero_in, external_request_one_in, timer0_ovf_in, timer1_ovf_in,
      timer2_ovf_in, serial_req_in, keypad_req_in, counter_array_req_in}))
      else $error("offer without request");
   a_ca_vector: assert property ($rose(irq_req_out) && irq_vector_out == 16'h0033
      |-> $past(counter_array_req_in))
      else $error("counter array vector without request");
   a_kbd_vector: assert property ($rose(irq_req_out) && irq_vector_out == 16'h004B
      |-> $past(keypad_req_in))
      else $error("keypad vector without request");
   a_nest_higher: assert property ($rose(irq_req_out) && $past(|act)
      |-> irq_level_out > $past(top))
      else $error("nested offer not above active level");
   a_top_block: assert property (act[3] |=> !$rose(irq_req_out))
      else $error("offer while highest level active");
endmodule

bind flic_top flic_top_chk flic_top_chk_inst (.*);

// file: tb/four_level_interrupt_controller_test.sv
// Testbench: register bus, source table, nesting and event interrupt
`timescale 1ns/100ps
module four_level_interrupt_controller_test
   import flic_pkg::*;
;
   typedef struct packed {
      logic [7:0]  src, ie, ie2, pl, ph;
      logic [1:0]  pk;
      logic [15:0] vec;
      logic [1:0]  lvl;
   } flic_row_t;
   logic        ref_clk = 1'b0;
   logic        rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, irq_lvl;
   logic [7:0]  src;
   logic [3:0]  dly;
   logic        ack, ret, ret_go, irq_req, evt_irq;
   logic [15:0] irq_vec;
   int          mismatches = 0;
   int          checks_done = 0;
   // A zero vector marks a row that must raise no offer
   flic_row_t   rows [16] = '{
      '{8'h01, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0003, 2'h0},
      '{8'h02, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h000B, 2'h0},
      '{8'h04, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0013, 2'h0},
      '{8'h08, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h001B, 2'h0},
      '{8'h10, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0023, 2'h0},
      '{8'h20, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h002B, 2'h0},
      '{8'h40, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0033, 2'h0},
      '{8'h80, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h004B, 2'h0},
      '{8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0003, 2'h0},
      '{8'hC0, 8'hFF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0033, 2'h0},
      '{8'h12, 8'hFF, 8'h01, 8'h02, 8'h10, 2'h0, 16'h0023, 2'h2},
      '{8'h81, 8'hFF, 8'h01, 8'h01, 8'h00, 2'h3, 16'h004B, 2'h3},
      '{8'h0C, 8'hFF, 8'h01, 8'h08, 8'h04, 2'h0, 16'h0013, 2'h2},
      '{8'hFF, 8'h7F, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0000, 2'h0},
      '{8'h20, 8'hDF, 8'h01, 8'h00, 8'h00, 2'h0, 16'h0000, 2'h0},
      '{8'h80, 8'hFF, 8'h00, 8'h00, 8'h00, 2'h0, 16'h0000, 2'h0}};
   flic_row_t   r;

   always #5 ref_clk = ~ref_clk;

   flic_top flic_top_inst (
      .ref_clk_in(ref_clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
      .hresp_out(hresp), .external_request_zero_in(src[0]), .timer0_ovf_in(src[1]),
      .external_request_one_in(src[2]), .timer1_ovf_in(src[3]), .serial_req_in(src[4]),
      .timer2_ovf_in(src[5]), .counter_array_req_in(src[6]), .keypad_req_in(src[7]),
      .irq_ack_in(ack), .irq_return_in(ret), .irq_req_out(irq_req),
      .irq_vector_out(irq_vec), .irq_level_out(irq_lvl), .evt_irq_out(evt_irq));

   flic_core_model flic_core_model_inst (
      .clk_in(ref_clk), .rst_n_in(rst_n), .req_in(irq_req), .ret_go_in(ret_go),
      .dly_in(dly), .ack_out(ack), .ret_out(ret));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {22'h0, a, 2'b00};
      hwrite <= w;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      ahb(1'b1, a, {24'h0, d}, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      cmp(q, exp);
      cmp({31'h0, hresp}, 32'h0);
   endtask

   task automatic expect_irq(input logic [15:0] v, input logic [1:0] l);
      logic got;
      got = 1'b0;
      for (int k = 0; k < 12 && !got; k++) begin
         @(posedge ref_clk);
         got = (irq_req === 1'b1);
      end
      cmp({31'h0, got}, {31'h0, v !== 16'h0});
      if (v !== 16'h0) begin
         cmp({16'h0, irq_vec}, {16'h0, v});
         cmp({30'h0, irq_lvl}, {30'h0, l});
      end
   endtask

   task automatic settle();
      while (irq_req === 1'b1) @(posedge ref_clk);
   endtask

   task automatic ret_pulse();
      @(posedge ref_clk);
      ret_go <= 1'b1;
      @(posedge ref_clk);
      ret_go <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end

   initial begin
      {hsel, hwrite, ret_go, rst_n} = 4'h0;
      {haddr, hwdata, htrans, src, dly} = '0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(OFS_IRQ_ENABLE, 32'h0);
      rd_chk(OFS_IRQ_ENABLE2, 32'h0);
      rd_chk(8'h10, 32'h0);
      wr(OFS_IRQ_ENABLE, 8'hA5);
      rd_chk(OFS_IRQ_ENABLE, 32'hA5);
      wr(OFS_PRIO_LOW, 8'hFF);
      rd_chk(OFS_PRIO_LOW, 32'h7F);
      for (int i = 0; i < 16; i++) begin
         r = rows[i];
         wr(OFS_IRQ_ENABLE, r.ie);
         wr(OFS_IRQ_ENABLE2, r.ie2);
         wr(OFS_PRIO_LOW, r.pl);
         wr(OFS_PRIO_HIGH, r.ph);
         wr(OFS_PRIO_LOW2, {7'h0, r.pk[0]});
         wr(OFS_PRIO_HIGH2, {7'h0, r.pk[1]});
         dly <= 4'(i % 4);
         src <= r.src;
         expect_irq(r.vec, r.lvl);
         src <= 8'h00;
         settle();
         if (r.vec !== 16'h0) ret_pulse();
      end
      wr(OFS_PRIO_LOW, 8'h46);
      wr(OFS_PRIO_HIGH, 8'h50);
      wr(OFS_PRIO_LOW2, 8'h01);
      wr(OFS_PRIO_HIGH2, 8'h01);
      wr(OFS_IRQ_ENABLE2, 8'h01);
      rd_chk(OFS_EVT_STATUS, 32'h5);
      src <= 8'h02;
      expect_irq(VEC_TMR0, 2'h1);
      src <= 8'h04;
      settle();
      expect_irq(16'h0, 2'h0);
      src <= 8'h14;
      expect_irq(VEC_SER, 2'h2);
      src <= 8'h04;
      settle();
      src <= 8'h84;
      expect_irq(VEC_KBD, 2'h3);
      src <= 8'h04;
      settle();
      src <= 8'h44;
      expect_irq(16'h0, 2'h0);
      src <= 8'h04;
      repeat (3) ret_pulse();
      expect_irq(VEC_EXT1, 2'h1);
      src <= 8'h00;
      settle();
      ret_pulse();
      // Masked events must stay silent even with status bits set
      cmp({31'h0, evt_irq}, 32'h0);
      wr(OFS_EVT_MASK, 8'h07);
      repeat (2) @(posedge ref_clk);
      cmp({31'h0, evt_irq}, 32'h1);
      rd_chk(OFS_EVT_STATUS, 32'h7);
      repeat (3) @(posedge ref_clk);
      cmp({31'h0, evt_irq}, 32'h0);
      // Mid-run reset drops a pending offer and clears the first enable register
      src <= 8'h01;
      expect_irq(VEC_EXT0, 2'h0);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp({31'h0, irq_req}, 32'h0);
      rst_n <= 1'b1;
      rd_chk(OFS_IRQ_ENABLE, 32'h0);
      expect_irq(16'h0, 2'h0);
      src <= 8'h00;
      summarize();
   end
endmodule
